// >>> core/ddr3_mode_pkg.sv
// package for the mode register decode block: field positions, codes, types
// assumes a 13-bit address bus and a 3-bit bank address on the command pins
package ddr3_mode_pkg;

	// =====================================================
	// widths and geometry
	localparam int MR_W = 13;
	localparam int BA_W = 3;
	localparam int COL_W = 3;
	localparam int BEATS_PER_CK = 2;
	localparam int CL_W = 5;
	localparam int RL_W = 6;

	// =====================================================
	// mode register 0 fields
	localparam int MR0_BL_LO = 0;
	localparam int MR0_CL_EXT = 2;
	localparam int MR0_BT = 3;
	localparam int MR0_CL_LO = 4;
	localparam int MR0_TM = 7;
	localparam int MR0_DLL_RST = 8;
	localparam int MR0_WR_LO = 9;
	localparam int MR0_PPD = 12;

	// =====================================================
	// mode register 1 fields
	localparam int MR1_DLL_DIS = 0;
	localparam int MR1_AL_LO = 3;
	localparam int MR1_WLVL = 7;
	localparam int MR1_QOFF = 12;

	// =====================================================
	// codes and reset values
	localparam logic [1:0] BL_FIXED8 = 2'h0;
	localparam logic [1:0] BL_OTF = 2'h1;
	localparam logic [1:0] BL_CHOP4 = 2'h2;
	localparam logic [1:0] AL_CL1 = 2'h1;
	localparam logic [1:0] AL_CL2 = 2'h2;
	localparam logic [2:0] BA_MR0 = 3'h0;
	localparam logic [2:0] BA_MR1 = 3'h1;
	localparam logic [MR_W-1:0] MR_RST = 13'h0000;
	localparam logic [CL_W-1:0] CL_BASE = 5'h04;
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [1:0] CHOP_LAST = 2'h1;
	localparam int WR_CHOP_PULL = 2;

	// =====================================================
	// carriers
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [BA_W-1:0] ba;
		logic [MR_W-1:0] addr;
	} cmd_t;

	typedef struct packed {
		logic [MR_W-1:0] mr0;
		logic [MR_W-1:0] mr1;
	} mode_t;

	typedef enum logic [2:0] {
		RD_IDLE = 3'b001,
		RD_DATA = 3'b010,
		RD_HIZ = 3'b100
	} rd_state_t;

endpackage

// >>> core/burst_order.sv
// column order of one beat within an eight-column burst
// assumes start column and beat index are stable in the same cycle
`timescale 1ns/1ps
module burst_order (
	// burst setup
	input wire logic [2:0] i_start,
	input wire logic i_interleave,
	// beat
	input wire logic [2:0] i_beat,
	output logic [2:0] o_col
);
	// =====================================================
	// order
	// sequential wraps within a half, then the other half
	wire [2:0] seq_col = {i_start[2] ^ i_beat[2], 2'(i_start[1:0] + i_beat[1:0])};
	wire [2:0] ilv_col = i_start ^ i_beat;
	assign o_col = i_interleave ? ilv_col : seq_col;
endmodule

// >>> core/mode_sync.sv
// word crossing by request/acknowledge toggles
// assumes the source waits for o_busy low before a new send
`timescale 1ns/1ps
module mode_sync #(
	parameter int W = 26
) (
	// common reset
	input wire logic i_reset_n,
	// source side
	input wire logic i_src_clk,
	input wire logic i_send,
	input wire logic [W-1:0] i_data,
	output logic o_busy,
	// destination side
	input wire logic i_clk,
	output logic [W-1:0] o_data,
	output logic o_valid
);
	// =====================================================
	// source
	logic req_ff;
	logic ack_s1_ff;
	logic ack_s2_ff;
	logic [W-1:0] hold_ff;
	logic ack_ff;
	assign o_busy = req_ff ^ ack_s2_ff;
	always_ff @(posedge i_src_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			req_ff <= 1'b0;
			hold_ff <= '0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
		end else begin
			ack_s1_ff <= ack_ff;
			ack_s2_ff <= ack_s1_ff;
			if (i_send && !o_busy) begin
				req_ff <= ~req_ff;
				hold_ff <= i_data;
			end
		end
	end

	// =====================================================
	// destination
	// hold_ff is steady while the request is in flight
	logic req_s1_ff;
	logic req_s2_ff;
	wire req_new = req_s2_ff ^ ack_ff;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			ack_ff <= 1'b0;
			o_data <= '0;
			o_valid <= 1'b0;
		end else begin
			req_s1_ff <= req_ff;
			req_s2_ff <= req_s1_ff;
			ack_ff <= req_s2_ff;
			o_valid <= req_new;
			if (req_new) begin
				o_data <= hold_ff;
			end
		end
	end
endmodule

// >>> core/ddr3_mode_decode.sv
// mode register decode and burst sequencing of a ddr3-class sdram
// assumes command pins are sampled on the link clock i_ck; reset is the device reset pin
//
// Function
// - cas latency decoded from mode register zero bits a2 and a6..a4.
// - only whole-cycle cas latencies; no half-cycle setting.
// - read data appears after additive latency plus cas latency cycles.
// - bit a3 picks sequential (0) or interleaved (1) order.
// - bits a1..a0 pick fixed chop, fixed burst-8, or per-command a12.
// - burst-8 reads follow xor order or half-wrapped sequential order.
// - chop reads give four beats, then outputs high impedance four beats.
// - chop writes use column bit a2 half, ascending, low bits ignored.
// - burst-8 writes ignore start column, ascending columns 0 to 7.
// - fixed chop writes pull write reference two clocks earlier.
// - dll reset bit clears itself after the reset is carried out.
// - write recovery field plus trp sets tdal for auto-precharge.
// - a12 zero freezes dll in precharge power-down; slow exit.
// - a12 one keeps dll running in precharge power-down; fast exit.
// - mode register one written with bank address one.
// - output disable turns off the data drivers (o_dq_oe).
// - mode register zero written with all bank address bits low.
`timescale 1ns/1ps
module ddr3_mode_decode #(
	parameter int SLOT_AW = 6,
	parameter int WR_REF_CK = 8,
	parameter int TRP_CK = 11
) (
	// system clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// link clock and command pins
	input wire logic i_ck,
	input wire ddr3_mode_pkg::cmd_t i_cmd,
	// read burst, link domain
	output logic o_rd_valid,
	output logic o_dq_oe,
	output logic [5:0] o_rd_cols,
	// write burst, link domain
	output logic o_wr_start,
	output logic o_wr_chop,
	output logic [2:0] o_wr_first_col,
	output logic o_wr_ref,
	// decoded fields, link domain
	output logic [4:0] o_cl,
	output logic [5:0] o_rl,
	output logic [4:0] o_dal,
	output logic o_test_mode,
	output logic o_dll_freeze_pd,
	output logic o_dll_reset,
	output logic o_write_level,
	output logic o_out_disable,
	// mode image, system domain
	output ddr3_mode_pkg::mode_t o_sys_mode,
	output logic o_sys_mode_valid,
	output logic o_sys_dll_reset
);
	// =====================================================
	// command decode
	function automatic logic cmd_is(input ddr3_mode_pkg::cmd_t c, input logic [3:0] code);
		cmd_is = ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == code);
	endfunction

	wire is_mrs = cmd_is(i_cmd, 4'h0);
	wire is_read = cmd_is(i_cmd, 4'h5);
	wire is_write = cmd_is(i_cmd, 4'h4);
	wire wr_mr0 = is_mrs && (i_cmd.ba == ddr3_mode_pkg::BA_MR0);
	wire wr_mr1 = is_mrs && (i_cmd.ba == ddr3_mode_pkg::BA_MR1);

	// =====================================================
	// mode registers
	logic [12:0] mr0_ff;
	logic [12:0] mr1_ff;
	logic dll_tgl_ff;
	logic dirty_ff;
	wire dll_rst_now = mr0_ff[ddr3_mode_pkg::MR0_DLL_RST];
	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mr0_ff <= ddr3_mode_pkg::MR_RST;
			mr1_ff <= ddr3_mode_pkg::MR_RST;
			dll_tgl_ff <= 1'b0;
		end else begin
			// the dll reset is issued the cycle after it is written
			if (dll_rst_now) begin
				mr0_ff[ddr3_mode_pkg::MR0_DLL_RST] <= 1'b0;
				dll_tgl_ff <= ~dll_tgl_ff;
			end
			// a fresh write wins over the self-clear
			if (wr_mr0) begin
				mr0_ff <= i_cmd.addr;
			end
			if (wr_mr1) begin
				mr1_ff <= i_cmd.addr;
			end
		end
	end

	// =====================================================
	// latency decode
	wire [1:0] bl_mode = mr0_ff[ddr3_mode_pkg::MR0_BL_LO +: 2];
	wire interleave = mr0_ff[ddr3_mode_pkg::MR0_BT];
	wire [4:0] cl_code = {1'b0, mr0_ff[ddr3_mode_pkg::MR0_CL_EXT], mr0_ff[ddr3_mode_pkg::MR0_CL_LO +: 3]};
	// integer cycles only, there is no half-cycle bit
	wire [4:0] cl = 5'(ddr3_mode_pkg::CL_BASE + cl_code);
	wire [1:0] al_code = mr1_ff[ddr3_mode_pkg::MR1_AL_LO +: 2];
	wire [4:0] al = (al_code == ddr3_mode_pkg::AL_CL1) ? 5'(cl - 5'h01) :
		(al_code == ddr3_mode_pkg::AL_CL2) ? 5'(cl - 5'h02) : 5'h00;
	wire [5:0] rl = 6'({1'b0, al} + {1'b0, cl});
	wire [2:0] wr_code = mr0_ff[ddr3_mode_pkg::MR0_WR_LO +: 3];
	wire [4:0] wr_ck = (wr_code == 3'h0) ? 5'h10 :
		(wr_code <= 3'h4) ? 5'(wr_code + 3'h4) : 5'({wr_code, 1'b0});
	wire [4:0] dal = 5'(wr_ck + 5'(TRP_CK));
	wire out_disable = mr1_ff[ddr3_mode_pkg::MR1_QOFF];

	// chop-4 or burst-8 per command
	wire cmd_chop = (bl_mode == ddr3_mode_pkg::BL_CHOP4) ||
		((bl_mode == ddr3_mode_pkg::BL_OTF) && !i_cmd.addr[12]);
	wire fixed_chop = (bl_mode == ddr3_mode_pkg::BL_CHOP4);

	// =====================================================
	// read slot ring
	// one slot per link cycle; reads land at their due cycle
	localparam int SLOTS = 1 << SLOT_AW;
	logic [SLOT_AW-1:0] ptr_ff;
	logic slot_vld_ff [SLOTS];
	logic slot_chop_ff [SLOTS];
	logic [2:0] slot_col_ff [SLOTS];
	wire [SLOT_AW-1:0] due_idx = SLOT_AW'(ptr_ff + SLOT_AW'(rl) - 1'b1);
	wire slot_hit = slot_vld_ff[ptr_ff];

	genvar g;
	generate
		for (g = 0; g < SLOTS; g++) begin : g_slot
			always_ff @(posedge i_ck or negedge i_reset_n) begin
				if (!i_reset_n) begin
					slot_vld_ff[g] <= 1'b0;
					slot_chop_ff[g] <= 1'b0;
					slot_col_ff[g] <= 3'h0;
				end else if (is_read && (due_idx == SLOT_AW'(g))) begin
					slot_vld_ff[g] <= 1'b1;
					slot_chop_ff[g] <= cmd_chop;
					slot_col_ff[g] <= i_cmd.addr[2:0];
				end else if (ptr_ff == SLOT_AW'(g)) begin
					slot_vld_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ptr_ff <= '0;
		end else begin
			ptr_ff <= SLOT_AW'(ptr_ff + 1'b1);
		end
	end

	// =====================================================
	// read burst sequencer
	ddr3_mode_pkg::rd_state_t rd_state_ff;
	ddr3_mode_pkg::rd_state_t nxt_rd_state;
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic [2:0] col_ff;
	logic [2:0] nxt_col;
	logic chop_ff;
	logic nxt_chop;
	wire [1:0] cnt_inc = 2'(cnt_ff + 1'b1);

	always_comb begin
		nxt_rd_state = rd_state_ff;
		nxt_cnt = cnt_inc;
		nxt_col = col_ff;
		nxt_chop = chop_ff;
		if (slot_hit) begin
			nxt_rd_state = ddr3_mode_pkg::RD_DATA;
			nxt_cnt = 2'h0;
			nxt_col = slot_col_ff[ptr_ff];
			nxt_chop = slot_chop_ff[ptr_ff];
		end else begin
			case (rd_state_ff)
				ddr3_mode_pkg::RD_IDLE: begin
					nxt_cnt = 2'h0;
				end
				ddr3_mode_pkg::RD_DATA: begin
					if (cnt_ff == ddr3_mode_pkg::BURST_LAST) begin
						nxt_rd_state = ddr3_mode_pkg::RD_IDLE;
					end else if (chop_ff && (cnt_ff == ddr3_mode_pkg::CHOP_LAST)) begin
						nxt_rd_state = ddr3_mode_pkg::RD_HIZ;
					end
				end
				ddr3_mode_pkg::RD_HIZ: begin
					if (cnt_ff == ddr3_mode_pkg::BURST_LAST) begin
						nxt_rd_state = ddr3_mode_pkg::RD_IDLE;
					end
				end
				default: begin
					nxt_rd_state = ddr3_mode_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// two beats per link clock, rising then falling
	wire [5:0] beat_cols;
	generate
		for (g = 0; g < ddr3_mode_pkg::BEATS_PER_CK; g++) begin : g_beat
			burst_order u_order (
				.i_start(nxt_col),
				.i_interleave(interleave),
				.i_beat({nxt_cnt, 1'(g)}),
				.o_col(beat_cols[g*3 +: 3])
			);
		end
	endgenerate

	wire rd_drive = (nxt_rd_state == ddr3_mode_pkg::RD_DATA);

	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_state_ff <= ddr3_mode_pkg::RD_IDLE;
			cnt_ff <= 2'h0;
			col_ff <= 3'h0;
			chop_ff <= 1'b0;
			o_rd_valid <= 1'b0;
			o_dq_oe <= 1'b0;
			o_rd_cols <= 6'h00;
		end else begin
			rd_state_ff <= nxt_rd_state;
			cnt_ff <= nxt_cnt;
			col_ff <= nxt_col;
			chop_ff <= nxt_chop;
			o_rd_valid <= rd_drive;
			o_dq_oe <= rd_drive && !out_disable;
			o_rd_cols <= rd_drive ? beat_cols : 6'h00;
		end
	end

	// =====================================================
	// write burst and write reference
	// a later write restarts the reference count of an earlier one
	logic [4:0] ref_cnt_ff;
	wire [4:0] ref_load = fixed_chop ? 5'(WR_REF_CK - ddr3_mode_pkg::WR_CHOP_PULL) : 5'(WR_REF_CK);
	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_cnt_ff <= 5'h00;
			o_wr_start <= 1'b0;
			o_wr_chop <= 1'b0;
			o_wr_first_col <= 3'h0;
			o_wr_ref <= 1'b0;
		end else begin
			o_wr_start <= is_write;
			o_wr_ref <= (ref_cnt_ff == 5'h01);
			if (is_write) begin
				ref_cnt_ff <= ref_load;
				o_wr_chop <= cmd_chop;
				// chop keeps only the half bit; burst-8 always from column 0
				o_wr_first_col <= cmd_chop ? {i_cmd.addr[2], 2'h0} : 3'h0;
			end else if (ref_cnt_ff != 5'h00) begin
				ref_cnt_ff <= 5'(ref_cnt_ff - 1'b1);
			end
		end
	end

	// =====================================================
	// decoded field outputs
	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_cl <= 5'h00;
			o_rl <= 6'h00;
			o_dal <= 5'h00;
			o_test_mode <= 1'b0;
			o_dll_freeze_pd <= 1'b0;
			o_dll_reset <= 1'b0;
			o_write_level <= 1'b0;
			o_out_disable <= 1'b0;
		end else begin
			o_cl <= cl;
			o_rl <= rl;
			o_dal <= dal;
			o_test_mode <= mr0_ff[ddr3_mode_pkg::MR0_TM];
			o_dll_freeze_pd <= !mr0_ff[ddr3_mode_pkg::MR0_PPD];
			o_dll_reset <= dll_rst_now;
			o_write_level <= mr1_ff[ddr3_mode_pkg::MR1_WLVL];
			o_out_disable <= out_disable;
		end
	end

	// =====================================================
	// crossing to the system clock
	// the image is resent once the crossing is free, so the last write always lands
	logic send_busy;
	wire send_now = dirty_ff && !send_busy;
	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dirty_ff <= 1'b1;
		end else begin
			dirty_ff <= wr_mr0 || wr_mr1 || dll_rst_now || (dirty_ff && send_busy);
		end
	end

	mode_sync #(
		.W(2 * ddr3_mode_pkg::MR_W)
	) u_mode_sync (
		.i_reset_n(i_reset_n),
		.i_src_clk(i_ck),
		.i_send(send_now),
		.i_data({mr0_ff, mr1_ff}),
		.o_busy(send_busy),
		.i_clk(i_clk),
		.o_data(o_sys_mode),
		.o_valid(o_sys_mode_valid)
	);

	// dll reset event as a toggle
	logic dll_s1_ff;
	logic dll_s2_ff;
	logic dll_s3_ff;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dll_s1_ff <= 1'b0;
			dll_s2_ff <= 1'b0;
			dll_s3_ff <= 1'b0;
			o_sys_dll_reset <= 1'b0;
		end else begin
			dll_s1_ff <= dll_tgl_ff;
			dll_s2_ff <= dll_s1_ff;
			dll_s3_ff <= dll_s2_ff;
			o_sys_dll_reset <= dll_s2_ff ^ dll_s3_ff;
		end
	end
endmodule

// >>> testbench/mem_ctrl_model.sv
// controller-side model: issues mode, read and write commands on the link clock
// assumes the caller spaces commands; idle cycles deselect the device
`timescale 1ns/1ps
module mem_ctrl_model (
	// link clock
	input wire logic i_ck,
	// command pins
	output ddr3_mode_pkg::cmd_t o_cmd
);
	// ====================
	// command issue
	initial o_cmd = '1;
	// rcw is {ras_n, cas_n, we_n}; a whole word each time, held over one rising edge
	task send(input logic [2:0] rcw, input logic [2:0] ba, input logic [12:0] a, input int gap);
		@(negedge i_ck);
		o_cmd = {1'h0, rcw, ba, a};
		@(negedge i_ck);
		// deselect with inverted lines so stale values never look valid
		o_cmd = {1'h1, ~rcw, ~ba, ~a};
		repeat (gap) @(negedge i_ck);
	endtask
endmodule

// >>> testbench/ddr3_mode_decode_monitor.sv
// link-domain assertions on the mode register decode block
// assumes it is bound into ddr3_mode_decode; commands sampled at rising i_ck
`timescale 1ns/1ps
module ddr3_mode_decode_monitor #(
	parameter int WR_REF_CK = 8,
	parameter int TRP_CK = 11
) (
	// link clock, reset and command pins
	input wire logic i_ck,
	input wire logic i_reset_n,
	input wire ddr3_mode_pkg::cmd_t i_cmd,
	// observed outputs
	input wire logic o_rd_valid,
	input wire logic o_dq_oe,
	input wire logic [5:0] o_rd_cols,
	input wire logic o_wr_start,
	input wire logic o_wr_chop,
	input wire logic [2:0] o_wr_first_col,
	input wire logic o_wr_ref,
	input wire logic [4:0] o_cl,
	input wire logic [5:0] o_rl,
	input wire logic [4:0] o_dal,
	input wire logic o_test_mode,
	input wire logic o_dll_freeze_pd,
	input wire logic o_dll_reset,
	input wire logic o_write_level,
	input wire logic o_out_disable
);
	// reference pulse is registered one cycle after the count reaches its end
	localparam int REF8 = WR_REF_CK + 1;
	localparam int REF4 = REF8 - ddr3_mode_pkg::WR_CHOP_PULL;
	logic [12:0] m0_ff, m1_ff, m1_d1_ff;
	logic [6:0] cnt_ff;
	logic [2:0] col_ff, wcol_ff;
	logic chop_ff, wchop_ff;
	// ====================
	// command decode and shadow images
	wire [2:0] rcw = {i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
	wire mrs = !i_cmd.cs_n && rcw == 3'h0;
	wire mrs0 = mrs && i_cmd.ba == ddr3_mode_pkg::BA_MR0;
	wire mrs1 = mrs && i_cmd.ba == ddr3_mode_pkg::BA_MR1;
	wire rd = !i_cmd.cs_n && rcw == 3'h5;
	wire wr = !i_cmd.cs_n && rcw == 3'h4;
	wire fixc = m0_ff[1:0] == ddr3_mode_pkg::BL_CHOP4;
	wire chop = fixc || (m0_ff[1:0] == ddr3_mode_pkg::BL_OTF && !i_cmd.addr[12]);
	// o_rl trails the register by one cycle, so the shadow is delayed once
	wire [5:0] al = m1_d1_ff[4:3] == ddr3_mode_pkg::AL_CL1 ? {1'h0, o_cl} - 6'h01 :
		m1_d1_ff[4:3] == ddr3_mode_pkg::AL_CL2 ? {1'h0, o_cl} - 6'h02 : 6'h00;
	wire [4:0] wr_ck = m0_ff[11:9] == 3'h0 ? 5'h10 : m0_ff[11:9] < 3'h5 ? {2'h0, m0_ff[11:9]} + 5'h04 :
		{1'h0, m0_ff[11:9], 1'h0};
	always_ff @(posedge i_ck or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{m0_ff, m1_ff, m1_d1_ff, cnt_ff, col_ff, wcol_ff, chop_ff, wchop_ff} <= '0;
		end else begin
			m0_ff <= mrs0 ? i_cmd.addr : m0_ff;
			m1_ff <= mrs1 ? i_cmd.addr : m1_ff;
			m1_d1_ff <= m1_ff;
			cnt_ff <= rd ? 7'h01 : cnt_ff + {6'h00, cnt_ff != 7'h7F};
			{col_ff, chop_ff} <= rd ? {i_cmd.addr[2:0], chop} : {col_ff, chop_ff};
			{wcol_ff, wchop_ff} <= wr ? {chop ? {i_cmd.addr[2], 2'h0} : 3'h0, chop} : {wcol_ff, wchop_ff};
		end
	end
	// ====================
	// assertions
	default clocking cb @(posedge i_ck); endclocking
	default disable iff (!i_reset_n);
	sequence s_mrs0; mrs0 ##1 !mrs ##1 !mrs; endsequence
	sequence s_mrs1; mrs1 ##1 !mrs ##1 !mrs; endsequence
	sequence s_b8; o_rd_valid [*4] ##1 !o_rd_valid; endsequence
	sequence s_c4; o_rd_valid [*2] ##1 (!o_rd_valid && !o_dq_oe) [*2]; endsequence
	AST_CL: assert property (s_mrs0 |-> ##1 o_cl == {1'h0, m0_ff[2], m0_ff[6:4]} + ddr3_mode_pkg::CL_BASE)
		else $error("cas latency decode wrong");
	AST_RL: assert property (o_rl == {1'h0, o_cl} + al)
		else $error("read latency not al plus cl");
	AST_PPD: assert property (s_mrs0 |-> ##1 o_dll_freeze_pd == !m0_ff[12] && o_test_mode == m0_ff[7])
		else $error("power-down dll or test mode decode wrong");
	AST_DAL: assert property (s_mrs0 |-> ##1 o_dal == wr_ck + TRP_CK)
		else $error("dal decode wrong");
	AST_MR1: assert property (s_mrs1 |-> ##1 o_out_disable == m1_ff[12] && o_write_level == m1_ff[7])
		else $error("mode register one decode wrong");
	AST_QOFF: assert property (o_out_disable |-> !o_dq_oe)
		else $error("drivers on while outputs disabled");
	AST_DLLRST: assert property (mrs0 && i_cmd.addr[8] ##1 !mrs0 |-> ##1 o_dll_reset ##1 !o_dll_reset)
		else $error("dll reset not a self-clearing pulse");
	AST_RD_LAT: assert property ($rose(o_rd_valid) |-> cnt_ff == {1'h0, o_rl})
		else $error("read data at wrong latency");
	AST_RD_B8: assert property ($rose(o_rd_valid) && !chop_ff |-> s_b8)
		else $error("burst of eight length wrong");
	AST_RD_C4: assert property ($rose(o_rd_valid) && chop_ff |-> s_c4)
		else $error("chop read tail not idle");
	AST_COL0: assert property ($rose(o_rd_valid) |-> o_rd_cols[2:0] == col_ff)
		else $error("first beat not start column");
	AST_WR: assert property (wr |-> ##1 o_wr_start && o_wr_first_col == wcol_ff && o_wr_chop == wchop_ff)
		else $error("write start or first column wrong");
	AST_WREF8: assert property (wr && !fixc |-> ##REF8 o_wr_ref)
		else $error("write reference late or early");
	AST_WREF4: assert property (wr && fixc |-> ##REF4 o_wr_ref)
		else $error("chop write reference not pulled in");
endmodule
bind ddr3_mode_decode ddr3_mode_decode_monitor #(.WR_REF_CK(WR_REF_CK), .TRP_CK(TRP_CK)) i_mon (.i_ck, .i_reset_n,
	.i_cmd, .o_rd_valid, .o_dq_oe, .o_rd_cols, .o_wr_start, .o_wr_chop, .o_wr_first_col, .o_wr_ref, .o_cl, .o_rl,
	.o_dal, .o_test_mode, .o_dll_freeze_pd, .o_dll_reset, .o_write_level, .o_out_disable);

// >>> testbench/test_ddr3_mode_decode.sv
// self-checking bench for the mode register decode block
// assumes the controller model drives the command pins on the link clock
`timescale 1ns/1ps
module test_ddr3_mode_decode;
	localparam int TRP = 11;
	logic i_clk, i_ck, i_reset_n;
	ddr3_mode_pkg::cmd_t i_cmd;
	logic o_rd_valid, o_dq_oe, o_wr_start, o_wr_chop, o_wr_ref, o_test_mode, o_dll_freeze_pd, o_dll_reset;
	logic o_write_level, o_out_disable, o_sys_mode_valid, o_sys_dll_reset;
	logic [5:0] o_rd_cols, o_rl;
	logic [2:0] o_wr_first_col, col;
	logic [4:0] o_cl, o_dal;
	ddr3_mode_pkg::mode_t o_sys_mode;
	logic [12:0] m0, m1;
	logic otf8, ch;
	int n_errors = 0;
	int checks = 0;
	int n;
	int n_upd = 0;
	int n_base;
	ddr3_mode_decode #(.SLOT_AW(6), .WR_REF_CK(8), .TRP_CK(TRP)) i_dut (.i_clk, .i_reset_n, .i_ck, .i_cmd, .o_rd_valid,
		.o_dq_oe, .o_rd_cols, .o_wr_start, .o_wr_chop, .o_wr_first_col, .o_wr_ref, .o_cl, .o_rl, .o_dal, .o_test_mode,
		.o_dll_freeze_pd, .o_dll_reset, .o_write_level, .o_out_disable, .o_sys_mode, .o_sys_mode_valid, .o_sys_dll_reset);
	mem_ctrl_model i_ctrl (.i_ck, .o_cmd(i_cmd));
	// image updates seen in the system domain, sampled off the launching edge
	always @(negedge i_clk) begin
		if (o_sys_mode_valid === 1'h1) n_upd++;
	end
	// ====================
	// clocks and watchdog
	initial begin
		i_clk = 1'h0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		i_ck = 1'h0;
		#5.3;
		forever #32 i_ck = ~i_ck;
	end
	initial begin
		#300000;
		n_errors++;
		results();
	end
	// ====================
	// checking and expectations
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results();
		if (n_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [2:0] bcol(input logic [2:0] s, input logic il, input logic [2:0] b);
		bcol = il ? s ^ b : {s[2] ^ b[2], s[1:0] + b[1:0]};
	endfunction
	function automatic logic [4:0] ecl(input logic [12:0] m);
		ecl = {1'h0, m[2], m[6:4]} + 5'h04;
	endfunction
	function automatic logic [5:0] erl(input logic [12:0] a, input logic [12:0] b);
		logic [5:0] c;
		c = {1'h0, ecl(a)};
		erl = b[4:3] == 2'h1 ? c + c - 6'h01 : b[4:3] == 2'h2 ? c + c - 6'h02 : c;
	endfunction
	function automatic logic [4:0] edal(input logic [2:0] w);
		edal = (w == 3'h0 ? 5'h10 : w < 3'h5 ? {2'h0, w} + 5'h04 : {1'h0, w, 1'h0}) + 5'(TRP);
	endfunction
	function automatic logic echop(input logic [12:0] m, input logic a12);
		echop = m[1:0] == 2'h2 || (m[1:0] == 2'h1 && !a12);
	endfunction
	// ====================
	// main sequence
	initial begin
		i_reset_n = 1'h0;
		n = $urandom(23);
		repeat (2) @(negedge i_ck);
		i_reset_n = 1'h1;
		@(negedge i_ck);
		chk({o_cl, o_rl, o_out_disable}, {5'h04, 6'h04, 1'h0});
		for (int i = 0; i < 12; i++) begin
			// test mode and dll reset bits kept clear
			m0 = 13'($urandom) & 13'h1E7C;
			m0[1:0] = 2'(i % 3);
			m0[3] = 1'((i / 3) % 2);
			// bench tWR is six cycles, so write recovery code one is too small
			if (m0[11:9] == 3'h1) m0[11:9] = 3'h2;
			if (i < 2) {m0[2], m0[6:4]} = {4{i[0]}};
			// dll enabled, nominal termination off, outputs off once
			m1 = (13'($urandom) & 13'h00A2) | (13'(i % 3) << 3);
			m1[12] = (i == 4);
			i_ctrl.send(3'h0, 3'h0, m0, 4);
			i_ctrl.send(3'h0, 3'h1, m1, 4);
			chk(o_cl, ecl(m0));
			chk(o_dal, edal(m0[11:9]));
			chk({o_test_mode, o_dll_freeze_pd, o_write_level, o_out_disable}, {1'h0, !m0[12], m1[7], m1[12]});
			chk(o_sys_mode, {m0, m1});
			col = 3'($urandom);
			otf8 = 1'($urandom);
			ch = echop(m0, otf8);
			i_ctrl.send(3'h5, 3'h0, {otf8, 9'($urandom), col}, 0);
			n = 0;
			while (o_rd_valid !== 1'h1 && n < 80) begin
				@(negedge i_ck);
				n++;
			end
			chk(n, erl(m0, m1) - 6'h01);
			for (int k = 0; k < 4; k++) begin
				if (ch && k > 1) chk({o_rd_valid, o_dq_oe}, 2'h0);
				else chk({o_rd_valid, o_dq_oe, o_rd_cols}, {1'h1, !m1[12], bcol(col, m0[3], 3'(2 * k + 1)),
					bcol(col, m0[3], 3'(2 * k))});
				@(negedge i_ck);
			end
			col = 3'($urandom);
			otf8 = 1'($urandom);
			ch = echop(m0, otf8);
			i_ctrl.send(3'h4, 3'h0, {otf8, 9'($urandom), col}, 0);
			// start pulse stands one cycle only, right after the command edge
			chk({o_wr_start, o_wr_chop, o_wr_first_col}, {1'h1, ch, ch ? {col[2], 2'h0} : 3'h0});
			// let the write reference pass before the next command
			repeat (12) @(negedge i_ck);
		end
		// unmapped bank address must leave both images alone
		i_ctrl.send(3'h0, 3'h2, ~m0, 4);
		chk({o_cl, o_sys_mode}, {ecl(m0), m0, m1});
		// dll reset after the dll was enabled
		n_base = n_upd;
		i_ctrl.send(3'h0, 3'h0, m0 | 13'h0100, 0);
		n = 0;
		while (o_sys_dll_reset !== 1'h1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		chk(n < 200, 1'h1);
		// lock wait before any read would be allowed
		repeat (8) @(negedge i_ck);
		// cleared reset bit must reach the system image: write, then self-clear
		chk(o_sys_mode, {m0, m1});
		chk(n_upd - n_base, 2);
		results();
	end
endmodule
